// [rtl/chg_i2c_register_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module chg_i2c_register_bank #(
   parameter logic [6:0] SLAVE_ADDR = chg_pkg::I2C_ADDR
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaDriveN,
   input  wire logic        detDone,
   input  wire logic [4:0]  detCode,
   input  wire logic        wdExpire,
   input  wire logic        chargingActive,
   output logic             hizEn,
   output logic [11:0]      limitMa,
   output logic             monOut,
   output logic             monDriveN
);
   logic       wrStrobe;
   logic [7:0] wrData;
   logic       wrFirst;
   logic       rdNext;
   logic [7:0] rdData;
   logic [7:0] ptr_q;
   logic       hiz_q;
   logic [1:0] monSel_q;
   logic [4:0] limCode_q;
   logic [7:0] bank_q [1:15];
   logic       hizEn_q;
   logic [11:0] limitMa_q;
   logic       monOut_q;
   logic       monDriveN_q;

   // unsigned code to milliamps; top code jumps to its own value
   function automatic logic [11:0] limitMaFn(input logic [4:0] code);
      if (code == chg_pkg::LIM_TOP_CODE) begin
         return chg_pkg::LIM_TOP_MA;
      end
      return 12'(12'(code) * chg_pkg::LIM_STEP_MA + chg_pkg::LIM_STEP_MA);
   endfunction : limitMaFn

   chg_i2c_slave #(
      .SLAVE_ADDR (SLAVE_ADDR)
   ) u_slave (
      .clk       (clk),
      .rst       (rst),
      .sclIn     (sclIn),
      .sdaIn     (sdaIn),
      .txData    (rdData),
      .sdaOut    (sdaOut),
      .sdaDriveN (sdaDriveN),
      .wrStrobe  (wrStrobe),
      .wrData    (wrData),
      .wrFirst   (wrFirst),
      .rdNext    (rdNext)
   );

   wire       regWrite  = wrStrobe & ~wrFirst;
   wire       wrLimit   = regWrite & (ptr_q == chg_pkg::REG_INPUT_LIMIT);
   wire       regRstReq = regWrite & (ptr_q == chg_pkg::REG_RESET_CTRL)
                          & wrData[chg_pkg::REG_RST_BIT];
   wire       bankReset = rst | regRstReq;
   wire [7:0] limitReg  = {hiz_q, monSel_q, limCode_q};
   wire       inRange   = (ptr_q <= chg_pkg::REG_LAST);
   wire       forcedOn  = |bank_q[chg_pkg::REG_STAT_SET][chg_pkg::STAT_SET_HI:chg_pkg::STAT_SET_LO];
   assign rdData = (ptr_q == chg_pkg::REG_INPUT_LIMIT) ? limitReg
                 : inRange ? bank_q[ptr_q[3:0]]
                 : chg_pkg::READ_BEYOND;
   wire       monFloat  = (monSel_q == chg_pkg::MON_FLOAT);
   // reserved code falls through to the charging-state source
   wire       monLevel  = (monSel_q == chg_pkg::MON_FORCED) ? forcedOn : chargingActive;

   // first data byte sets the pointer, each later byte moves it on
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_q <= 8'h00;
      end else if (wrStrobe & wrFirst) begin
         ptr_q <= wrData;
      end else if (regWrite | rdNext) begin
         ptr_q <= 8'(ptr_q + 8'h01);
      end
   end

   always_ff @(posedge clk) begin
      if (bankReset | wdExpire) begin
         hiz_q <= 1'b0;
      end else if (wrLimit) begin
         hiz_q <= wrData[chg_pkg::HIZ_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (bankReset) begin
         monSel_q <= chg_pkg::RESET_LIMIT_REG[chg_pkg::MON_HI:chg_pkg::MON_LO];
      end else if (wrLimit) begin
         monSel_q <= wrData[chg_pkg::MON_HI:chg_pkg::MON_LO];
      end
   end

   // detection beats a host write landing in the same cycle
   always_ff @(posedge clk) begin
      if (bankReset) begin
         limCode_q <= chg_pkg::RESET_LIMIT_REG[chg_pkg::LIM_HI:0];
      end else if (detDone) begin
         limCode_q <= detCode;
      end else if (wrLimit) begin
         limCode_q <= wrData[chg_pkg::LIM_HI:0];
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi <= 15; gi++) begin : g_bank
         // reset request bit is a strobe and never reads back as set
         wire [7:0] keepMask = (gi == int'(chg_pkg::REG_RESET_CTRL))
                               ? 8'(~(8'h01 << chg_pkg::REG_RST_BIT)) : 8'hFF;
         always_ff @(posedge clk) begin
            if (bankReset) begin
               bank_q[gi] <= chg_pkg::RESET_OTHER_REG;
            end else if (regWrite && (ptr_q == 8'(gi))) begin
               bank_q[gi] <= wrData & keepMask;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         hizEn_q <= 1'b0;
         limitMa_q <= chg_pkg::RESET_LIMIT_MA;
         monOut_q <= 1'b0;
         monDriveN_q <= 1'b1;
      end else begin
         hizEn_q <= hiz_q;
         limitMa_q <= limitMaFn(limCode_q);
         monOut_q <= monLevel;
         monDriveN_q <= monFloat;
      end
   end

   assign hizEn     = hizEn_q;
   assign limitMa   = limitMa_q;
   assign monOut    = monOut_q;
   assign monDriveN = monDriveN_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_detect;
      detDone && !regRstReq;
   endsequence

   sequence s_limit_settled;
      ##2 (limitMa == limitMaFn($past(detCode, 2)));
   endsequence

   a_read_layout: assert property (
      (ptr_q == chg_pkg::REG_INPUT_LIMIT) |-> (rdData[chg_pkg::HIZ_BIT] == hiz_q)
         && (rdData[chg_pkg::MON_HI:chg_pkg::MON_LO] == monSel_q)
         && (rdData[chg_pkg::LIM_HI:0] == limCode_q))
      else $error("limit register read layout wrong");

   a_reset_default: assert property (
      $past(rst) |-> (limitReg == chg_pkg::RESET_LIMIT_REG) ##1 (limitMa == chg_pkg::RESET_LIMIT_MA))
      else $error("limit register not at its reset value");

   a_detect_overwrite: assert property (
      s_detect |-> s_limit_settled)
      else $error("detection result did not reach the limit");

   a_host_keep: assert property (
      !detDone && !wrLimit && !regRstReq |=> $stable(limCode_q))
      else $error("limit code changed without cause");

   a_write_store: assert property (
      wrLimit && !detDone && !regRstReq && !wdExpire |=> (limitReg == $past(wrData)))
      else $error("written limit register not stored");

   a_hiz_clear: assert property (
      wdExpire |=> !hiz_q ##1 !hizEn)
      else $error("watchdog did not clear high impedance");

   a_limit_decode: assert property (
      (limCode_q == chg_pkg::LIM_TOP_CODE) [*2] |-> (limitMa == chg_pkg::LIM_TOP_MA))
      else $error("top code not decoded to its own limit");

   a_mon_float: assert property (
      monFloat |=> monDriveN)
      else $error("monitor output driven while floating");

   a_mon_reserved: assert property (
      (monSel_q == chg_pkg::MON_RESERVED) |=> !monDriveN && (monOut == $past(chargingActive)))
      else $error("reserved monitor code not treated as default");

   a_read_beyond: assert property (
      (ptr_q > chg_pkg::REG_LAST) |-> (rdData == chg_pkg::READ_BEYOND))
      else $error("read beyond bank not 0xFF");

   a_ptr_advance: assert property (
      regWrite || rdNext |=> (ptr_q == 8'($past(ptr_q) + 8'h01)))
      else $error("register pointer did not advance");
endmodule : chg_i2c_register_bank
`default_nettype wire

// [rtl/chg_i2c_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module chg_i2c_slave #(
   parameter logic [6:0] SLAVE_ADDR = chg_pkg::I2C_ADDR
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   input  wire logic [7:0] txData,
   output logic            sdaOut,
   output logic            sdaDriveN,
   output logic            wrStrobe,
   output logic [7:0]      wrData,
   output logic            wrFirst,
   output logic            rdNext
);
   chg_pkg::chg_i2c_state_t st_q;
   logic       sclPrev_q;
   logic       sdaPrev_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] txSh_q;
   logic       rw_q;
   logic       nack_q;
   logic       first_q;
   logic       drvN_q;
   logic       wrStrobe_q;
   logic       rdNext_q;
   logic       sdaOut_q;

   wire sclRise   = sclIn & ~sclPrev_q;
   wire sclFall   = ~sclIn & sclPrev_q;
   wire startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
   wire stopCond  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
   wire byteDone  = (cnt_q == chg_pkg::BYTE_BITS);
   wire addrHit   = (sh_q[7:1] == SLAVE_ADDR);

   assign sdaOut    = sdaOut_q;
   assign sdaDriveN = drvN_q;
   assign wrStrobe  = wrStrobe_q;
   assign wrData    = sh_q;
   assign wrFirst   = first_q;
   assign rdNext    = rdNext_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= chg_pkg::ST_IDLE;
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         txSh_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b1;
         first_q <= 1'b0;
         drvN_q <= 1'b1;
         wrStrobe_q <= 1'b0;
         rdNext_q <= 1'b0;
         sdaOut_q <= 1'b0;
      end else begin
         // open drain: the pin only ever pulls low
         sdaOut_q <= 1'b0;
         sclPrev_q <= sclIn;
         sdaPrev_q <= sdaIn;
         wrStrobe_q <= 1'b0;
         rdNext_q <= 1'b0;
         if (startCond) begin
            st_q <= chg_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            drvN_q <= 1'b1;
         end else if (stopCond) begin
            st_q <= chg_pkg::ST_IDLE;
            drvN_q <= 1'b1;
         end else if (sclRise) begin
            sh_q <= {sh_q[6:0], sdaIn};
            cnt_q <= 4'(cnt_q + 4'h1);
            nack_q <= sdaIn;
         end else if (sclFall) begin
            unique case (st_q)
               chg_pkg::ST_IDLE: ;
               chg_pkg::ST_ADDR: if (byteDone) begin
                  drvN_q <= ~addrHit;
                  rw_q <= sh_q[0];
                  st_q <= addrHit ? chg_pkg::ST_ACKA : chg_pkg::ST_IDLE;
               end
               chg_pkg::ST_ACKA: begin
                  cnt_q <= 4'h0;
                  first_q <= ~rw_q;
                  txSh_q <= txData;
                  drvN_q <= rw_q ? txData[7] : 1'b1;
                  st_q <= rw_q ? chg_pkg::ST_RDATA : chg_pkg::ST_WDATA;
               end
               chg_pkg::ST_WDATA: if (byteDone) begin
                  drvN_q <= 1'b0;
                  wrStrobe_q <= 1'b1;
                  st_q <= chg_pkg::ST_ACKW;
               end
               chg_pkg::ST_ACKW: begin
                  drvN_q <= 1'b1;
                  first_q <= 1'b0;
                  cnt_q <= 4'h0;
                  st_q <= chg_pkg::ST_WDATA;
               end
               chg_pkg::ST_RDATA: if (byteDone) begin
                  drvN_q <= 1'b1;
                  rdNext_q <= 1'b1;
                  st_q <= chg_pkg::ST_ACKR;
               end else begin
                  txSh_q <= {txSh_q[6:0], 1'b0};
                  drvN_q <= txSh_q[6];
               end
               chg_pkg::ST_ACKR: begin
                  // master ack asks for the next register, nack ends the read
                  cnt_q <= 4'h0;
                  txSh_q <= txData;
                  drvN_q <= nack_q ? 1'b1 : txData[7];
                  st_q <= nack_q ? chg_pkg::ST_IDLE : chg_pkg::ST_RDATA;
               end
            endcase
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_addr_ack_match: assert property (
      (st_q == chg_pkg::ST_ADDR) && sclFall && byteDone |=> (drvN_q == !$past(addrHit)))
      else $error("ack given to a foreign address");
endmodule : chg_i2c_slave
`default_nettype wire

// [rtl/chg_pkg.sv]
package chg_pkg;
   localparam logic [6:0]  I2C_ADDR        = 7'h6B;
   localparam int          REG_BITS        = 8;
   localparam logic [7:0]  REG_INPUT_LIMIT = 8'h00;
   localparam logic [7:0]  REG_RESET_CTRL  = 8'h0B;
   localparam logic [7:0]  REG_LAST        = 8'h0F;
   localparam logic [3:0]  REG_STAT_SET    = 4'hF;
   localparam logic [7:0]  READ_BEYOND     = 8'hFF;
   localparam logic [7:0]  RESET_LIMIT_REG = 8'h17;
   localparam logic [7:0]  RESET_OTHER_REG = 8'h00;
   localparam int          HIZ_BIT         = 7;
   localparam int          MON_HI          = 6;
   localparam int          MON_LO          = 5;
   localparam int          LIM_HI          = 4;
   localparam int          REG_RST_BIT     = 7;
   localparam int          STAT_SET_HI     = 3;
   localparam int          STAT_SET_LO     = 2;
   localparam logic [1:0]  MON_CHARGING    = 2'h0;
   localparam logic [1:0]  MON_FORCED      = 2'h1;
   localparam logic [1:0]  MON_RESERVED    = 2'h2;
   localparam logic [1:0]  MON_FLOAT       = 2'h3;
   localparam logic [4:0]  LIM_TOP_CODE    = 5'h1F;
   localparam logic [11:0] LIM_STEP_MA     = 12'h064;
   localparam logic [11:0] LIM_TOP_MA      = 12'hED8;
   localparam logic [11:0] RESET_LIMIT_MA  = 12'h960;
   localparam logic [3:0]  BYTE_BITS       = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACKA, ST_WDATA, ST_ACKW, ST_RDATA, ST_ACKR
   } chg_i2c_state_t;
endpackage : chg_pkg

// [sim/chg_i2c_master.sv]
`timescale 1ns/1ps
`default_nettype none
module chg_i2c_master (
   input  wire logic clk,
   input  wire logic sdaW,
   output logic      sclQ,
   output logic      sdaQ
);
   logic ack;
   initial begin
      sclQ = 1'b1;
      sdaQ = 1'b1;
      ack  = 1'b1;
   end
   // four clocks per phase, above the three the slave needs
   task automatic ph(input logic s, input logic d);
      @(posedge clk);
      sclQ <= s;
      sdaQ <= d;
      repeat (3) @(posedge clk);
   endtask : ph
   task automatic start();
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
      ph(1'b0, 1'b0);
   endtask : start
   task automatic stop();
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask : stop
   // 1 releases the line; the pull-up decides unless the slave pulls
   task automatic xfer(input logic [7:0] d, input logic mAck, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         ph(1'b0, d[i]);
         ph(1'b1, d[i]);
         #1 q[i] = sdaW;
      end
      ph(1'b0, mAck);
      ph(1'b1, mAck);
      #1 ack = sdaW;
   endtask : xfer
   task automatic poke(input logic [6:0] a);
      logic [7:0] x;
      start();
      xfer({a, 1'b0}, 1'b1, x);
      stop();
   endtask : poke
   task automatic wr(input logic [7:0] p, d0, d1, input int n);
      logic [7:0] x;
      start();
      xfer({chg_pkg::I2C_ADDR, 1'b0}, 1'b1, x);
      xfer(p, 1'b1, x);
      xfer(d0, 1'b1, x);
      if (n > 1) xfer(d1, 1'b1, x);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] p, input int n, output logic [7:0] q0, q1);
      logic [7:0] x;
      start();
      xfer({chg_pkg::I2C_ADDR, 1'b0}, 1'b1, x);
      xfer(p, 1'b1, x);
      start();
      xfer({chg_pkg::I2C_ADDR, 1'b1}, 1'b1, x);
      xfer(8'hFF, (n > 1) ? 1'b0 : 1'b1, q0);
      if (n > 1) xfer(8'hFF, 1'b1, q1);
      stop();
   endtask : rd
endmodule : chg_i2c_master
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, rst, detDone, wdExpire, chargingActive;
   logic [4:0]  detCode;
   logic        sdaOut, sdaDriveN, hizEn, monOut, monDriveN, mScl, mSda;
   logic [11:0] limitMa;
   logic [7:0]  q0, q1;
   int          mismatches, checks;
   int          codes[4] = '{0, 1, 30, 31};
   wire logic   sdaW = ((sdaDriveN == 1'b0) ? sdaOut : 1'b1) & mSda;
   chg_i2c_register_bank uut (.clk(clk), .rst(rst), .sclIn(mScl), .sdaIn(sdaW),
      .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .detDone(detDone), .detCode(detCode),
      .wdExpire(wdExpire), .chargingActive(chargingActive), .hizEn(hizEn),
      .limitMa(limitMa), .monOut(monOut), .monDriveN(monDriveN));
   chg_i2c_master m (.clk(clk), .sdaW(sdaW), .sclQ(mScl), .sdaQ(mSda));
   task automatic chk(input logic [11:0] seen, exp, input string msg);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   task automatic pulse(input int w);
      @(posedge clk);
      if (w == 1) wdExpire <= 1'b1;
      else detDone <= 1'b1;
      @(posedge clk);
      wdExpire <= 1'b0;
      detDone  <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : pulse
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // whole run is near 6.2k cycles
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      detDone = 1'b0;
      detCode = 5'h00;
      wdExpire = 1'b0;
      chargingActive = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(hizEn, 12'h000, "hiz rst");
      chk(limitMa, 12'h960, "limit rst");
      chk({monDriveN, monOut}, 12'h000, "mon rst");
      m.rd(8'h00, 2, q0, q1);
      chk(q0, 12'h017, "reg0 rst");
      chk(q1, 12'h000, "reg1 rst");
      m.poke(7'h2A);
      chk(m.ack, 12'h001, "foreign addr");
      m.wr(8'h0F, 8'h04, 8'h00, 1);
      chargingActive <= 1'b1;
      m.wr(8'h00, 8'h80, 8'h5A, 2);
      chk(m.ack, 12'h000, "own addr");
      chk(hizEn, 12'h001, "hiz set");
      chk(monOut, 12'h001, "mon charging");
      m.rd(8'h00, 2, q0, q1);
      chk(q0, 12'h080, "multi rd 0");
      chk(q1, 12'h05A, "multi rd 1");
      pulse(1);
      chk(hizEn, 12'h000, "wd clears hiz");
      chargingActive <= 1'b0;
      for (int c = 1; c < 4; c++) begin
         m.wr(8'h00, {1'b0, 2'(c), 5'h17}, 8'h00, 1);
         chk(monDriveN, 12'(c == 3), "mon float");
         if (c != 3) chk(monOut, 12'(c == 1), "mon forced or reserved");
         m.rd(8'h00, 1, q0, q1);
         chk(q0, 12'({1'b0, 2'(c), 5'h17}), "mon code stored");
      end
      foreach (codes[i]) begin
         m.wr(8'h00, 8'(codes[i]), 8'h00, 1);
         chk(limitMa, (codes[i] == 31) ? 12'hED8 : 12'(100 + 100 * codes[i]), "limit");
      end
      detCode <= 5'h05;
      pulse(0);
      chk(limitMa, 12'h258, "det limit");
      m.rd(8'h00, 1, q0, q1);
      chk(q0[4:0], 12'h005, "det code");
      m.wr(8'h00, 8'h8A, 8'h00, 1);
      chk(limitMa, 12'h44C, "host limit");
      chk(hizEn, 12'h001, "hiz set again");
      m.wr(8'h10, 8'h33, 8'h00, 1);
      m.rd(8'h10, 1, q0, q1);
      chk(q0, 12'h0FF, "beyond");
      m.wr(8'h0B, 8'h80, 8'h00, 1);
      m.rd(8'h00, 1, q0, q1);
      chk(q0, 12'h017, "reg reset");
      chk(limitMa, 12'h960, "limit after reg reset");
      chk(hizEn, 12'h000, "reg reset clears hiz");
      m.rd(8'h0B, 1, q0, q1);
      chk(q0, 12'h000, "reset bit");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
